// ==== rtl/dpll_ref_profile_regs.sv ====
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module dpll_ref_profile_regs
  import ref_profile_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host register port
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  // reference input b selection
  output logic reference_input_b_enable,
  output logic [1:0] reference_input_b_priority,
  // reference input b loop settings
  output logic [BW_W-1:0] loop_bw_scale,
  output logic loop_bw_zero,
  output logic high_phase_margin,
  // reference input b feedback divider
  output logic [DIV_W-1:0] integer_feedback_divisor_minus1,
  output logic [DIV_W:0] integer_feedback_divisor,
  output logic [FRAC_W-1:0] feedback_numerator,
  output logic [FRAC_W-1:0] feedback_modulus,
  output logic frac_bypass,
  // reference input c selection
  output logic reference_input_c_enable,
  output logic [1:0] reference_input_c_priority
);

  // byte storage of the whole bank
  logic [DATA_W-1:0] reg_file [REG_COUNT];
  logic [IDX_W:0] wr_map;
  logic [IDX_W:0] rd_map;

  // address to {hit, index}; used by the write and the read path
  function automatic logic [IDX_W:0] map_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    logic hit;
    begin
      d = a - BANK_BASE;
      hit = (a >= BANK_BASE) && (d < ADDR_W'(REG_COUNT));
      map_index = {hit, d[IDX_W-1:0]};
    end
  endfunction : map_index

  // decode both strobes' addresses
  assign wr_map = map_index(wr_addr);
  assign rd_map = map_index(rd_addr);

  // one writable byte per generate step, reserved bits masked off
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_byte
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          reg_file[gi] <= RESET_BYTE;
        end else if (wr_stb && wr_map[IDX_W] && (wr_map[IDX_W-1:0] == IDX_W'(gi))) begin
          reg_file[gi] <= wr_data & WR_MASK[gi];
        end
      end

      // reserved positions never hold a one
      AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_file[gi] & ~WR_MASK[gi]) == 8'h00)
        else $error("reserved bit set in bank byte");
    end
  endgenerate

  // read data for one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data <= RESET_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb && rd_map[IDX_W]) begin
        rd_data <= reg_file[rd_map[IDX_W-1:0]] & WR_MASK[rd_map[IDX_W-1:0]];
      end else begin
        rd_data <= RESET_BYTE; // unmapped or idle reads zero
      end
    end
  end

  // reference b selection fields
  assign reference_input_b_enable = reg_file[IDX_B_PRIO][PRIO_ENABLE_BIT];
  assign reference_input_b_priority =
    reg_file[IDX_B_PRIO][PRIO_LEVEL_MSB:PRIO_LEVEL_LSB];

  // bandwidth factor: two full bytes and bit 16 from the third
  assign loop_bw_scale = {reg_file[IDX_B_BW_TOP][BW_BIT16_POS],
                          reg_file[IDX_B_BW_MID],
                          reg_file[IDX_B_BW_LOW]};
  assign high_phase_margin = reg_file[IDX_B_BW_TOP][FILTER_SEL_POS];

  // divider fields assembled little endian
  assign integer_feedback_divisor_minus1 = {reg_file[IDX_B_DIV_TOP][DIV_TOP_MSB:0],
                                            reg_file[IDX_B_DIV_MID],
                                            reg_file[IDX_B_DIV_LOW]};
  assign feedback_numerator = {reg_file[IDX_B_NUM_TOP],
                               reg_file[IDX_B_NUM_MID],
                               reg_file[IDX_B_NUM_LOW]};
  assign feedback_modulus = {reg_file[IDX_B_MOD_TOP],
                             reg_file[IDX_B_MOD_MID],
                             reg_file[IDX_B_MOD_LOW]};

  // reference c selection fields
  assign reference_input_c_enable = reg_file[IDX_C_PRIO][PRIO_ENABLE_BIT];
  assign reference_input_c_priority =
    reg_file[IDX_C_PRIO][PRIO_LEVEL_MSB:PRIO_LEVEL_LSB];

  // actual divide ratio, one cycle behind the stored value
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      integer_feedback_divisor <= 19'h00001;
    end else begin
      integer_feedback_divisor <= {1'b0, integer_feedback_divisor_minus1} + 19'h00001;
    end
  end

  // fractional path is bypassed while the modulus is zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frac_bypass <= 1'b1;
    end else begin
      frac_bypass <= (feedback_modulus == 24'h000000);
    end
  end

  // flags a zero bandwidth factor, whose loop behaviour is undefined
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loop_bw_zero <= 1'b1;
    end else begin
      loop_bw_zero <= (loop_bw_scale == 17'h00000);
    end
  end

  // checks
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // host write and read shapes, one for each byte that is checked
  sequence seq_wr_b_prio;
    wr_stb && (wr_addr == ADDR_B_PRIO);
  endsequence

  sequence seq_wr_c_prio;
    wr_stb && (wr_addr == ADDR_C_PRIO);
  endsequence

  sequence seq_wr_bw_low;
    wr_stb && (wr_addr == ADDR_B_BW_LOW);
  endsequence

  sequence seq_wr_bw_mid;
    wr_stb && (wr_addr == ADDR_B_BW_MID);
  endsequence

  sequence seq_wr_bw_top;
    wr_stb && (wr_addr == ADDR_B_BW_TOP);
  endsequence

  sequence seq_wr_div_low;
    wr_stb && (wr_addr == ADDR_B_DIV_LOW);
  endsequence

  sequence seq_wr_div_mid;
    wr_stb && (wr_addr == ADDR_B_DIV_MID);
  endsequence

  sequence seq_wr_div_top;
    wr_stb && (wr_addr == ADDR_B_DIV_TOP);
  endsequence

  sequence seq_wr_num_low;
    wr_stb && (wr_addr == ADDR_B_NUM_LOW);
  endsequence

  sequence seq_wr_num_mid;
    wr_stb && (wr_addr == ADDR_B_NUM_MID);
  endsequence

  sequence seq_wr_num_top;
    wr_stb && (wr_addr == ADDR_B_NUM_TOP);
  endsequence

  sequence seq_wr_mod_low;
    wr_stb && (wr_addr == ADDR_B_MOD_LOW);
  endsequence

  sequence seq_wr_mod_mid;
    wr_stb && (wr_addr == ADDR_B_MOD_MID);
  endsequence

  sequence seq_wr_mod_top;
    wr_stb && (wr_addr == ADDR_B_MOD_TOP);
  endsequence

  sequence seq_wr_miss;
    wr_stb && !wr_map[IDX_W];
  endsequence

  sequence seq_rd_hit;
    rd_stb && rd_map[IDX_W];
  endsequence

  sequence seq_rd_miss;
    rd_stb && !rd_map[IDX_W];
  endsequence

  // first cycle out of reset shows the selection, bandwidth and fractional defaults
  AST_B_PRIO_RESET: assert property ($rose(rst_n) |->
    reference_input_b_priority == PRIO_HIGHEST && !reference_input_b_enable)
    else $error("reference b selection not at default after reset");

  AST_C_PRIO_RESET: assert property ($rose(rst_n) |->
    reference_input_c_priority == PRIO_HIGHEST && !reference_input_c_enable)
    else $error("reference c selection not at default after reset");

  AST_BW_RESET_ZERO: assert property ($rose(rst_n) |->
    loop_bw_scale == 17'h00000 && !high_phase_margin ##1 loop_bw_zero)
    else $error("bandwidth field not zero after reset");

  AST_FRAC_RESET_ZERO: assert property ($rose(rst_n) |->
    feedback_numerator == 24'h000000 && feedback_modulus == 24'h000000)
    else $error("fractional fields not zero after reset");

  // writes land in the right fields one cycle later
  AST_B_PRIO_WRITE: assert property (seq_wr_b_prio |=>
    reference_input_b_priority == $past(wr_data[2:1]) &&
    reference_input_b_enable == $past(wr_data[0]))
    else $error("reference b priority write not applied");

  AST_C_PRIO_WRITE: assert property (seq_wr_c_prio |=>
    reference_input_c_priority == $past(wr_data[2:1]) &&
    reference_input_c_enable == $past(wr_data[0]) &&
    reg_file[IDX_C_PRIO][7:3] == 5'h00)
    else $error("reference c priority write not applied");

  // bandwidth bytes and filter select
  AST_BW_LOW_BYTES: assert property (seq_wr_bw_low |=>
    loop_bw_scale[7:0] == $past(wr_data))
    else $error("bandwidth low byte misplaced");

  AST_BW_MID_WRITE: assert property (seq_wr_bw_mid |=>
    loop_bw_scale[15:8] == $past(wr_data))
    else $error("bandwidth middle byte misplaced");

  AST_BW_TOP_WRITE: assert property (seq_wr_bw_top |=>
    loop_bw_scale[16] == $past(wr_data[0]) &&
    high_phase_margin == $past(wr_data[1]))
    else $error("bandwidth top byte write not applied");

  // integer divisor bytes and the plus one ratio
  AST_DIV_LOW_WRITE: assert property (seq_wr_div_low |=>
    integer_feedback_divisor_minus1[7:0] == $past(wr_data))
    else $error("integer divisor low byte misplaced");

  AST_DIV_MID_WRITE: assert property (seq_wr_div_mid |=>
    integer_feedback_divisor_minus1[15:8] == $past(wr_data))
    else $error("integer divisor middle byte misplaced");

  AST_DIV_TOP_WRITE: assert property (seq_wr_div_top |=>
    integer_feedback_divisor_minus1[17:16] == $past(wr_data[1:0])
    ##1 integer_feedback_divisor[17:16] ==
        2'(({1'b0, $past(integer_feedback_divisor_minus1)} + 19'h00001) >> 16))
    else $error("integer divisor top bits or ratio wrong");

  AST_DIV_PLUS_ONE: assert property (1'b1 |=>
    integer_feedback_divisor == {1'b0, $past(integer_feedback_divisor_minus1)} + 19'h00001)
    else $error("divide ratio is not stored value plus one");

  // numerator bytes
  AST_NUM_BYTE_ORDER: assert property (seq_wr_num_low |=>
    feedback_numerator[7:0] == $past(wr_data))
    else $error("numerator low byte misplaced");

  AST_NUM_MID_WRITE: assert property (seq_wr_num_mid |=>
    feedback_numerator[15:8] == $past(wr_data))
    else $error("numerator middle byte misplaced");

  AST_NUM_TOP_WRITE: assert property (seq_wr_num_top |=>
    feedback_numerator[23:16] == $past(wr_data))
    else $error("numerator top byte misplaced");

  // modulus bytes
  AST_MOD_LOW_WRITE: assert property (seq_wr_mod_low |=>
    feedback_modulus[7:0] == $past(wr_data))
    else $error("modulus low byte misplaced");

  AST_MOD_MID_WRITE: assert property (seq_wr_mod_mid |=>
    feedback_modulus[15:8] == $past(wr_data))
    else $error("modulus middle byte misplaced");

  AST_MOD_BYTE_ORDER: assert property (seq_wr_mod_top |=>
    feedback_modulus[23:16] == $past(wr_data))
    else $error("modulus top byte misplaced");

  // writes outside the bank change nothing
  AST_MISS_WRITE_IGNORED: assert property (seq_wr_miss |=>
    $stable(loop_bw_scale) && $stable(integer_feedback_divisor_minus1) &&
    $stable(feedback_numerator) && $stable(feedback_modulus))
    else $error("write outside the bank changed a field");

  // status flags follow their fields with one cycle of delay
  AST_FRAC_BYPASS: assert property (1'b1 |=>
    frac_bypass == ($past(feedback_modulus) == 24'h000000))
    else $error("fractional bypass does not track zero modulus");

  AST_BW_ZERO_FLAG: assert property (1'b1 |=>
    loop_bw_zero == ($past(loop_bw_scale) == 17'h00000))
    else $error("zero bandwidth flag wrong");

  // reads answer in the next cycle only
  AST_READ_HIT: assert property (seq_rd_hit |=>
    rd_valid && rd_data == ($past(reg_file[rd_map[IDX_W-1:0]])))
    else $error("mapped read returned wrong data");

  AST_READ_MISS: assert property (seq_rd_miss |=> rd_valid && rd_data == 8'h00)
    else $error("unmapped read not zero");

  AST_READ_IDLE: assert property (!rd_stb |=> !rd_valid && rd_data == 8'h00)
    else $error("read data present without a read");

  AST_RESERVED_READ: assert property (rd_stb && (rd_addr == ADDR_B_DIV_TOP) |=>
    rd_data[7:2] == 6'h00)
    else $error("reserved divisor bits read nonzero");

  AST_RESERVED_READ_C: assert property (rd_stb && (rd_addr == ADDR_C_PRIO) |=>
    rd_data[7:3] == 5'h00)
    else $error("reserved reference c bits read nonzero");

endmodule : dpll_ref_profile_regs

// ==== rtl/ref_profile_pkg.sv ====
package ref_profile_pkg;
  // host port geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 14;
  localparam int IDX_W = 4;

  // bank placement, byte addresses
  localparam logic [15:0] BANK_BASE = 16'h044d;
  localparam logic [15:0] ADDR_B_PRIO = 16'h044d;
  localparam logic [15:0] ADDR_B_BW_LOW = 16'h044e;
  localparam logic [15:0] ADDR_B_BW_MID = 16'h044f;
  localparam logic [15:0] ADDR_B_BW_TOP = 16'h0450;
  localparam logic [15:0] ADDR_B_DIV_LOW = 16'h0451;
  localparam logic [15:0] ADDR_B_DIV_MID = 16'h0452;
  localparam logic [15:0] ADDR_B_DIV_TOP = 16'h0453;
  localparam logic [15:0] ADDR_B_NUM_LOW = 16'h0454;
  localparam logic [15:0] ADDR_B_NUM_MID = 16'h0455;
  localparam logic [15:0] ADDR_B_NUM_TOP = 16'h0456;
  localparam logic [15:0] ADDR_B_MOD_LOW = 16'h0457;
  localparam logic [15:0] ADDR_B_MOD_MID = 16'h0458;
  localparam logic [15:0] ADDR_B_MOD_TOP = 16'h0459;
  localparam logic [15:0] ADDR_C_PRIO = 16'h045a;

  // storage indices relative to the bank base
  localparam logic [3:0] IDX_B_PRIO = 4'h0;
  localparam logic [3:0] IDX_B_BW_LOW = 4'h1;
  localparam logic [3:0] IDX_B_BW_MID = 4'h2;
  localparam logic [3:0] IDX_B_BW_TOP = 4'h3;
  localparam logic [3:0] IDX_B_DIV_LOW = 4'h4;
  localparam logic [3:0] IDX_B_DIV_MID = 4'h5;
  localparam logic [3:0] IDX_B_DIV_TOP = 4'h6;
  localparam logic [3:0] IDX_B_NUM_LOW = 4'h7;
  localparam logic [3:0] IDX_B_NUM_MID = 4'h8;
  localparam logic [3:0] IDX_B_NUM_TOP = 4'h9;
  localparam logic [3:0] IDX_B_MOD_LOW = 4'ha;
  localparam logic [3:0] IDX_B_MOD_MID = 4'hb;
  localparam logic [3:0] IDX_B_MOD_TOP = 4'hc;
  localparam logic [3:0] IDX_C_PRIO = 4'hd;

  // field positions
  localparam int PRIO_ENABLE_BIT = 0;
  localparam int PRIO_LEVEL_LSB = 1;
  localparam int PRIO_LEVEL_MSB = 2;
  localparam int BW_BIT16_POS = 0;
  localparam int FILTER_SEL_POS = 1;
  localparam int DIV_TOP_MSB = 1;

  // field widths
  localparam int BW_W = 17;
  localparam int DIV_W = 18;
  localparam int FRAC_W = 24;

  // reset value shared by every byte
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] PRIO_HIGHEST = 2'h0;

  // writable bits per byte; zero positions are reserved
  localparam logic [7:0] WR_MASK [REG_COUNT] = '{
    8'h07, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07
  };
endpackage : ref_profile_pkg

// ==== verif/tb_dpll_ref_profile_regs.sv ====
`timescale 1ns/1ps
module tb_dpll_ref_profile_regs;
  import ref_profile_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  // host side stimulus
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] wr_addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic rd_stb = 1'b0;
  // observed outputs
  logic [7:0] rd_data;
  logic rd_valid, b_en, bw_zero, hpm, bypass, c_en;
  logic [1:0] b_prio, c_prio;
  logic [16:0] bw;
  logic [17:0] div_m1;
  logic [18:0] div;
  logic [23:0] num, modulus;
  logic [1:0] pv;
  int n_errors = 0;
  int checks = 0;
  // ordinary cases: address, byte written, byte read back
  row_t rows [16] = '{
    '{16'h044d, 8'h05, 8'h05}, '{16'h044e, 8'h34, 8'h34}, '{16'h044f, 8'h12, 8'h12},
    '{16'h0450, 8'hfe, 8'h02}, '{16'h0451, 8'h07, 8'h07}, '{16'h0452, 8'h9c, 8'h9c},
    '{16'h0453, 8'hfd, 8'h01}, '{16'h0454, 8'h56, 8'h56}, '{16'h0455, 8'h34, 8'h34},
    '{16'h0456, 8'h12, 8'h12}, '{16'h0457, 8'h21, 8'h21}, '{16'h0458, 8'h43, 8'h43},
    '{16'h0459, 8'h65, 8'h65}, '{16'h045a, 8'hfb, 8'h03}, '{16'h045b, 8'haa, 8'h00},
    '{16'h044c, 8'h5a, 8'h00}
  };

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  dpll_ref_profile_regs i_dpll_ref_profile_regs (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_addr(rd_addr), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
    .reference_input_b_enable(b_en), .reference_input_b_priority(b_prio),
    .loop_bw_scale(bw), .loop_bw_zero(bw_zero), .high_phase_margin(hpm),
    .integer_feedback_divisor_minus1(div_m1), .integer_feedback_divisor(div),
    .feedback_numerator(num), .feedback_modulus(modulus), .frac_bypass(bypass),
    .reference_input_c_enable(c_en), .reference_input_c_priority(c_prio)
  );

  // compare read data
  task automatic chk_byte(string name, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  // compare a field output
  task automatic chk_val(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  // read cycle, data in the next cycle only
  task automatic rd(logic [15:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk_val("rd_valid", 1, rd_valid);
    chk_byte("rd_data", exp, rd_data);
    @(posedge clk_sys);
    #1;
    chk_val("rd_valid_drop", 0, rd_valid);
    chk_byte("rd_data_idle", 8'h00, rd_data);
  endtask : rd

  // write followed by a read with no gap
  task automatic wr_rd(logic [15:0] a, logic [7:0] d, logic [7:0] exp);
    @(posedge clk_sys);
    wr_stb <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk_byte("readback", exp, rd_data);
  endtask : wr_rd

  // let the lagging status outputs catch up
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // watchdog at 3000 cycles, far beyond the expected run of about 155 cycles
  initial begin
    #(50 * 3000);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk_val("bypass_rst", 1, bypass);
    chk_val("div_rst", 1, div);
    for (int i = 0; i < REG_COUNT; i++) begin
      rd(BANK_BASE + 16'(i), 8'h00);
    end
    $display("test reset_values done");
    for (int i = 0; i < 16; i++) begin
      wr_rd(rows[i].a, rows[i].w, rows[i].e);
    end
    settle();
    chk_val("b_en", 1, b_en);
    chk_val("b_prio", 2, b_prio);
    chk_val("bw", 17'h01234, bw);
    chk_val("bw_zero", 0, bw_zero);
    chk_val("hpm", 1, hpm);
    chk_val("div_m1", 18'h19c07, div_m1);
    chk_val("div", 19'h19c08, div);
    chk_val("num", 24'h123456, num);
    chk_val("mod", 24'h654321, modulus);
    chk_val("bypass", 0, bypass);
    chk_val("c_en", 1, c_en);
    chk_val("c_prio", 1, c_prio);
    $display("test table done");
    for (int p = 0; p < 4; p++) begin
      pv = p[1:0];
      wr_rd(ADDR_B_PRIO, {5'h1f, pv, pv[0]}, {5'h00, pv, pv[0]});
      wr_rd(ADDR_C_PRIO, {5'h1f, pv, ~pv[0]}, {5'h00, pv, ~pv[0]});
      settle();
      chk_val("b_prio", pv, b_prio);
      chk_val("b_en", pv[0], b_en);
      chk_val("c_prio", pv, c_prio);
      chk_val("c_en", !pv[0], c_en);
    end
    $display("test priority_levels done");
    wr_rd(ADDR_B_MOD_TOP, 8'h80, 8'h80);
    wr_rd(ADDR_B_BW_TOP, 8'h01, 8'h01);
    settle();
    chk_val("mod", 24'h804321, modulus);
    chk_val("bypass", 0, bypass);
    chk_val("bw", 17'h11234, bw);
    chk_val("hpm", 0, hpm);
    wr_rd(ADDR_B_MOD_TOP, 8'h00, 8'h00);
    wr_rd(ADDR_B_MOD_LOW, 8'h00, 8'h00);
    wr_rd(ADDR_B_MOD_MID, 8'h00, 8'h00);
    settle();
    chk_val("mod_zero", 24'h000000, modulus);
    chk_val("bypass", 1, bypass);
    $display("test bypass_and_partial done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk_val("num_rst", 0, num);
    chk_val("bw_rst", 0, bw);
    chk_val("bw_zero_rst", 1, bw_zero);
    chk_val("b_en_rst", 0, b_en);
    rd(ADDR_B_NUM_TOP, 8'h00);
    $display("test mid_reset done");
    wrap_up();
  end
endmodule : tb_dpll_ref_profile_regs
